// ---- hw/plcs_defs.svh ----
// Offsets, bit positions, reset values and counts for the link control/status word.
// Included by plcs_link_regs only; definitions only.
`ifndef PLCS_DEFS_SVH
`define PLCS_DEFS_SVH

// Byte address of the combined control (15:0) and status (31:16) word
`define PLCS_LINK_OFFSET 8'hD0

// Control half, positions within the 32-bit word
`define PLCS_BIT_LINK_DISABLE 4
`define PLCS_BIT_RETRAIN 5
`define PLCS_BIT_COMMON_CLK 6
`define PLCS_BIT_EXT_SYNCH 7
`define PLCS_BIT_HW_WIDTH_DIS 9
`define PLCS_BIT_PORT_DEP0 10
`define PLCS_BIT_PORT_DEP1 11

// Status half
`define PLCS_SPEED_LSB 16
`define PLCS_SPEED_MSB 19
`define PLCS_WIDTH_LSB 20
`define PLCS_WIDTH_MSB 25
`define PLCS_BIT_TRAIN_ERR 26
`define PLCS_BIT_TRAINING 27
`define PLCS_BIT_SLOT_CLK 28
`define PLCS_BIT_DL_ACTIVE 29

// Reset values and speed codes
`define PLCS_RST_SPEED 4'h2
`define PLCS_RST_WIDTH 6'h01
`define PLCS_SPEED_2G5 4'h1
`define PLCS_SPEED_5G0 4'h2

// Ordered-set counts when extended synchronisation is on
`define PLCS_FTS_EXT 13'h1000
`define PLCS_TS1_EXT 13'h0400

`endif

// ---- hw/plcs_link_regs.sv ----
// Link control (low half) and link status (high half) word of one switch port.
// Assumes a same-clock config access port and same-clock training/DLL event inputs.
`timescale 1ns/1ps
`default_nettype none
`include "plcs_defs.svh"

module plcs_link_regs #(
   parameter bit UPSTREAM = 1'b0,            // One for the upstream port
   parameter logic [12:0] FTS_NORMAL = 13'h0080, // FTS count with synch off
   parameter logic [12:0] TS1_NORMAL = 13'h0010  // TS1 count with synch off
) (
   input wire logic i_clk,                   // Core clock, 20 MHz
   input wire logic i_nrst,                  // Async reset, active low
   input wire logic i_cfg_req,               // Config access strobe
   input wire logic i_cfg_wr,                // One for write
   input wire logic [7:0] i_cfg_addr,        // Byte address
   input wire logic [3:0] i_cfg_be,          // Byte enables
   input wire logic [31:0] i_cfg_wdata,      // Write data
   output logic o_cfg_ack,                   // Access done pulse
   output logic [31:0] o_cfg_rdata,          // Read data
   input wire logic i_train_start,           // Training began
   input wire logic i_train_fail,            // Training failed
   input wire logic i_train_l0,              // Training reached L0
   input wire logic [3:0] i_neg_speed,       // Agreed speed code
   input wire logic [5:0] i_neg_width,       // Agreed lane count
   input wire logic i_dl_active,             // DLL in DL_Active
   input wire logic i_slot_reference_strap,  // Slot clock strap pin
   input wire logic i_slot_clk_load,         // Loader override strobe
   input wire logic i_slot_clk_value,        // Loader override value
   output logic o_retrain,                   // Retrain request pulse
   output logic o_link_disable,              // Hold link disabled
   output logic o_common_clk,                // Common reference clock
   output logic o_ext_synch,                 // Extended synch on
   output logic [12:0] o_fts_count,          // FTS sets on L0s exit
   output logic [12:0] o_ts1_count           // TS1 sets on L1 exit
);

   if (FTS_NORMAL == 13'h0000 || TS1_NORMAL == 13'h0000) begin : g_chk
      $error("plcs_link_regs: ordered-set counts must be nonzero");
   end

   logic strap_value, strap_load;
   logic hit_wr, hit_lo, hit_hi, rd_hit;
   logic dis_d, ccfg_d, ext_d, retrain_d, hwwd_q, hwwd_d;
   logic [1:0] pdep_q, pdep_d;
   logic [12:0] fts_d, ts1_d;
   plcs_pkg::plcs_link_type link_q, link_d;
   logic [3:0] speed_q, speed_d;
   logic [5:0] width_q, width_d;
   logic err_q, err_d, dla_q, slot_q, slot_d, ack_d;
   logic [31:0] rdata_d;

   // Address decode for the single mapped word
   function automatic logic addr_hit(input logic [7:0] addr);
      addr_hit = (addr[7:2] == 6'(`PLCS_LINK_OFFSET >> 2));
   endfunction : addr_hit

   plcs_strap_capture u_strap (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_strap(i_slot_reference_strap),
      .o_value(strap_value),
      .o_load(strap_load)
   );

   assign hit_wr = i_cfg_req && i_cfg_wr && addr_hit(i_cfg_addr);
   assign hit_lo = hit_wr && i_cfg_be[0];
   assign hit_hi = hit_wr && i_cfg_be[1];
   assign rd_hit = i_cfg_req && !i_cfg_wr && addr_hit(i_cfg_addr);

   // Control half next values
   always_comb begin
      dis_d = o_link_disable;
      ccfg_d = o_common_clk;
      ext_d = o_ext_synch;
      hwwd_d = hwwd_q;
      pdep_d = pdep_q;
      retrain_d = 1'b0;
      if (hit_lo) begin
         ccfg_d = i_cfg_wdata[`PLCS_BIT_COMMON_CLK];
         ext_d = i_cfg_wdata[`PLCS_BIT_EXT_SYNCH];
         if (!UPSTREAM) begin
            dis_d = i_cfg_wdata[`PLCS_BIT_LINK_DISABLE];
            retrain_d = i_cfg_wdata[`PLCS_BIT_RETRAIN];
         end
      end
      if (hit_hi) begin
         hwwd_d = i_cfg_wdata[`PLCS_BIT_HW_WIDTH_DIS];
         if (!UPSTREAM) begin
            pdep_d = i_cfg_wdata[`PLCS_BIT_PORT_DEP1:`PLCS_BIT_PORT_DEP0];
         end
      end
      fts_d = ext_d ? `PLCS_FTS_EXT : FTS_NORMAL;
      ts1_d = ext_d ? `PLCS_TS1_EXT : TS1_NORMAL;
   end

   // Control half registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_link_disable <= 1'b0;
         o_common_clk <= 1'b0;
         o_ext_synch <= 1'b0;
         hwwd_q <= 1'b0;
         pdep_q <= 2'h0;
         o_retrain <= 1'b0;
         o_fts_count <= FTS_NORMAL;
         o_ts1_count <= TS1_NORMAL;
      end else begin
         o_link_disable <= dis_d;
         o_common_clk <= ccfg_d;
         o_ext_synch <= ext_d;
         hwwd_q <= hwwd_d;
         pdep_q <= pdep_d;
         o_retrain <= retrain_d;
         o_fts_count <= fts_d;
         o_ts1_count <= ts1_d;
      end
   end

   // Training tracker and status next values
   always_comb begin
      link_d = link_q;
      speed_d = speed_q;
      width_d = width_q;
      err_d = err_q;
      slot_d = slot_q;
      case (link_q)
         plcs_pkg::PLCS_LINK_DOWN,
         plcs_pkg::PLCS_LINK_UP: begin
            if (i_train_start || o_retrain) begin
               link_d = plcs_pkg::PLCS_LINK_TRAINING;
            end
         end
         plcs_pkg::PLCS_LINK_TRAINING: begin
            // training ends on L0 or failure
            if (i_train_l0) begin
               link_d = plcs_pkg::PLCS_LINK_UP;
            end else if (i_train_fail) begin
               link_d = plcs_pkg::PLCS_LINK_DOWN;
            end
         end
         default: link_d = plcs_pkg::PLCS_LINK_DOWN;
      endcase
      if (i_train_l0) begin
         speed_d = i_neg_speed;
         width_d = i_neg_width;
      end
      if (i_train_fail) begin
         err_d = 1'b1;
      end else if (i_train_l0) begin
         err_d = 1'b0;
      end
      // strap at reset, loader override later
      if (i_slot_clk_load) begin
         slot_d = i_slot_clk_value;
      end else if (strap_load) begin
         slot_d = strap_value;
      end
   end

   // Status half registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         link_q <= plcs_pkg::PLCS_LINK_DOWN;
         speed_q <= `PLCS_RST_SPEED;
         width_q <= `PLCS_RST_WIDTH;
         err_q <= 1'b0;
         dla_q <= 1'b0;
         slot_q <= 1'b0;
      end else begin
         link_q <= link_d;
         speed_q <= speed_d;
         width_q <= width_d;
         err_q <= err_d;
         dla_q <= i_dl_active;
         slot_q <= slot_d;
      end
   end

   // Read data assembly; unmapped reads return zero
   always_comb begin
      ack_d = i_cfg_req;
      rdata_d = 32'h0000_0000;
      if (rd_hit) begin
         rdata_d[`PLCS_BIT_RETRAIN] = 1'b0;
         rdata_d[`PLCS_BIT_LINK_DISABLE] = o_link_disable;
         rdata_d[`PLCS_BIT_COMMON_CLK] = o_common_clk;
         rdata_d[`PLCS_BIT_EXT_SYNCH] = o_ext_synch;
         rdata_d[`PLCS_BIT_HW_WIDTH_DIS] = hwwd_q;
         rdata_d[`PLCS_BIT_PORT_DEP1:`PLCS_BIT_PORT_DEP0] = pdep_q;
         rdata_d[`PLCS_SPEED_MSB:`PLCS_SPEED_LSB] = speed_q;
         rdata_d[`PLCS_WIDTH_MSB:`PLCS_WIDTH_LSB] = width_q;
         rdata_d[`PLCS_BIT_TRAIN_ERR] = err_q;
         rdata_d[`PLCS_BIT_TRAINING] = (link_q == plcs_pkg::PLCS_LINK_TRAINING);
         rdata_d[`PLCS_BIT_SLOT_CLK] = slot_q;
         rdata_d[`PLCS_BIT_DL_ACTIVE] = dla_q;
      end
   end

   // Config answer registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cfg_ack <= 1'b0;
         o_cfg_rdata <= 32'h0000_0000;
      end else begin
         o_cfg_ack <= ack_d;
         o_cfg_rdata <= rdata_d;
      end
   end

   property p_retrain_zero;
      @(posedge i_clk) disable iff (!i_nrst)
      o_cfg_ack |-> !o_cfg_rdata[`PLCS_BIT_RETRAIN];
   endproperty
   a_retrain_zero: assert property (p_retrain_zero) else $error("retrain read nonzero");
   property p_common_clk;
      @(posedge i_clk) disable iff (!i_nrst)
      hit_lo |=> o_common_clk == $past(i_cfg_wdata[`PLCS_BIT_COMMON_CLK]);
   endproperty
   a_common_clk: assert property (p_common_clk) else $error("common clock not stored");
   property p_fts_ext;
      @(posedge i_clk) disable iff (!i_nrst)
      o_ext_synch |-> o_fts_count == `PLCS_FTS_EXT;
   endproperty
   a_fts_ext: assert property (p_fts_ext) else $error("FTS count wrong");
   property p_ts1_ext;
      @(posedge i_clk) disable iff (!i_nrst)
      o_ext_synch |-> o_ts1_count == `PLCS_TS1_EXT;
   endproperty
   a_ts1_ext: assert property (p_ts1_ext) else $error("TS1 count wrong");
   property p_upstream_zero;
      @(posedge i_clk) disable iff (!i_nrst)
      UPSTREAM |-> (pdep_q == 2'h0 && !o_link_disable && !o_retrain);
   endproperty
   a_upstream_zero: assert property (p_upstream_zero) else $error("upstream bit set");
   property p_err_clear;
      @(posedge i_clk) disable iff (!i_nrst)
      (i_train_l0 && !i_train_fail) |=> !err_q;
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");
   property p_err_set;
      @(posedge i_clk) disable iff (!i_nrst)
      i_train_fail |=> err_q;
   endproperty
   a_err_set: assert property (p_err_set) else $error("error flag not set");
   property p_dla;
      @(posedge i_clk) disable iff (!i_nrst)
      rd_hit |=> o_cfg_rdata[`PLCS_BIT_DL_ACTIVE] == $past(i_dl_active, 2);
   endproperty
   a_dla: assert property (p_dla) else $error("DL active wrong");
   property p_retrain_start;
      @(posedge i_clk) disable iff (!i_nrst)
      (hit_lo && i_cfg_wdata[`PLCS_BIT_RETRAIN] && !UPSTREAM)
         |=> o_retrain ##1 link_q == plcs_pkg::PLCS_LINK_TRAINING;
   endproperty
   a_retrain_start: assert property (p_retrain_start) else $error("retrain not started");
   property p_width_latch;
      @(posedge i_clk) disable iff (!i_nrst)
      i_train_l0 |=> (width_q == $past(i_neg_width) && speed_q == $past(i_neg_speed));
   endproperty
   a_width_latch: assert property (p_width_latch) else $error("speed/width not latched");

endmodule : plcs_link_regs
`default_nettype wire

// ---- hw/plcs_pkg.sv ----
// Types shared by the link control/status block.
// Assumes plcs_defs.svh is on the include path.
package plcs_pkg;

   // Link training progress as seen by the register bank
   typedef enum logic [1:0] {
      PLCS_LINK_DOWN,
      PLCS_LINK_TRAINING,
      PLCS_LINK_UP
   } plcs_link_type;

   typedef logic [31:0] plcs_word_type;

endpackage : plcs_pkg

// ---- hw/plcs_strap_capture.sv ----
// Slot clock strap synchroniser and one-shot capture after reset release.
// Assumes the strap pin is static and asynchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module plcs_strap_capture (
   input wire logic i_clk,        // Core clock
   input wire logic i_nrst,       // Async reset, active low
   input wire logic i_strap,      // Raw strap pin
   output logic o_value,          // Captured strap level
   output logic o_load            // One-cycle capture pulse
);

   logic meta_q;
   logic sync_q;
   logic [1:0] wait_q;
   logic [1:0] wait_d;
   logic done_q;
   logic done_d;
   logic load_d;
   logic value_d;

   // Two-flop synchroniser
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= i_strap;
         sync_q <= meta_q;
      end
   end

   // Wait for the synchroniser to fill, then capture once
   always_comb begin
      wait_d = wait_q;
      done_d = done_q;
      load_d = 1'b0;
      value_d = o_value;
      if (!done_q) begin
         if (wait_q == 2'h2) begin
            done_d = 1'b1;
            load_d = 1'b1;
            value_d = sync_q;
         end else begin
            wait_d = wait_q + 2'h1;
         end
      end
   end

   // Capture registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wait_q <= 2'h0;
         done_q <= 1'b0;
         o_load <= 1'b0;
         o_value <= 1'b0;
      end else begin
         wait_q <= wait_d;
         done_q <= done_d;
         o_load <= load_d;
         o_value <= value_d;
      end
   end

endmodule : plcs_strap_capture
`default_nettype wire

// ---- verification/pcie_link_control_status_test.sv ----
// Testbench: config accesses to a downstream and an upstream port word.
// Assumes the partner model drives the training inputs of both ports.
`timescale 1ns/1ps
`default_nettype none

module pcie_link_control_status_test;
   localparam logic [12:0] FTSN = 13'h0055;
   localparam logic [12:0] TS1N = 13'h0033;
   logic i_clk, i_nrst, req, wr, strap, sload, sval, go, fail, ack, ack_up;
   logic retr, retr_up, rt, rt_up, ldis, cclk, esync, ts, tf, tl, dl;
   logic [3:0] be, spd, nspd;
   logic [5:0] wid, nwid;
   logic [7:0] addr;
   logic [12:0] fts, ts1;
   logic [31:0] wdata, rdata, rdata_up, rd, rd_up;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;

   plcs_link_regs #(.UPSTREAM(1'b0), .FTS_NORMAL(FTSN), .TS1_NORMAL(TS1N)) DUT (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_cfg_req(req), .i_cfg_wr(wr), .i_cfg_addr(addr),
      .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_ack(ack), .o_cfg_rdata(rdata),
      .i_train_start(ts), .i_train_fail(tf), .i_train_l0(tl), .i_neg_speed(nspd),
      .i_neg_width(nwid), .i_dl_active(dl), .i_slot_reference_strap(strap),
      .i_slot_clk_load(sload), .i_slot_clk_value(sval), .o_retrain(retr),
      .o_link_disable(ldis), .o_common_clk(cclk), .o_ext_synch(esync),
      .o_fts_count(fts), .o_ts1_count(ts1));
   plcs_link_regs #(.UPSTREAM(1'b1), .FTS_NORMAL(FTSN), .TS1_NORMAL(TS1N)) dut_up (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_cfg_req(req), .i_cfg_wr(wr), .i_cfg_addr(addr),
      .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_ack(ack_up), .o_cfg_rdata(rdata_up),
      .i_train_start(ts), .i_train_fail(tf), .i_train_l0(tl), .i_neg_speed(nspd),
      .i_neg_width(nwid), .i_dl_active(dl), .i_slot_reference_strap(strap),
      .i_slot_clk_load(sload), .i_slot_clk_value(sval), .o_retrain(retr_up),
      .o_link_disable(), .o_common_clk(), .o_ext_synch(), .o_fts_count(), .o_ts1_count());
   plcs_partner_model #(.TRAIN_CYCLES(4)) partner (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_go(go), .i_retrain(retr), .i_link_disable(ldis),
      .i_fail(fail), .i_speed(spd), .i_width(wid), .o_train_start(ts), .o_train_fail(tf),
      .o_train_l0(tl), .o_neg_speed(nspd), .o_neg_width(nwid), .o_dl_active(dl));

   // Clock, 50 ns period
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   // Hang guard
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Expected word; f is {link active, slot clock, training, error}
   function automatic logic [31:0] word(input logic [15:0] c, input logic [3:0] s,
                                        input logic [5:0] w, input logic [3:0] f);
      word = {2'h0, f, w, s, c};
   endfunction : word

   // One config access, request held for one cycle, answer one cycle later
   task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
                         input logic [31:0] d);
      @(negedge i_clk);
      req = 1'b1;
      wr = w;
      addr = a;
      be = b;
      wdata = d;
      @(negedge i_clk);
      req = 1'b0;
      check({30'h0, ack, ack_up}, 32'h3);
      rd = rdata;
      rd_up = rdata_up;
      rt = retr;
      rt_up = retr_up;
   endtask : access

   task automatic read_d0;
      access(1'b0, 8'hD0, 4'hF, 32'h0);
   endtask : read_d0

   task automatic train(input logic f, input logic [3:0] s, input logic [5:0] w);
      @(negedge i_clk);
      go = 1'b1;
      fail = f;
      spd = s;
      wid = w;
      @(negedge i_clk);
      go = 1'b0;
   endtask : train

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test

   initial begin
      {i_nrst, req, wr, sload, sval, go, fail} = '0;
      strap = 1'b1;
      be = 4'h0;
      addr = 8'h00;
      wdata = 32'h0;
      spd = 4'h1;
      wid = 6'h01;
      repeat (2) @(negedge i_clk);
      i_nrst = 1'b1;
      repeat (5) @(negedge i_clk);
      read_d0();
      check(rd, word(16'h0, 4'h2, 6'h01, 4'b0100));
      check({19'h0, fts}, {19'h0, FTSN});
      check({19'h0, ts1}, {19'h0, TS1N});
      access(1'b1, 8'hD0, 4'hF, 32'hFFFF_FFCF);
      read_d0();
      check(rd, word(16'h0EC0, 4'h2, 6'h01, 4'b0100));
      check(rd_up, word(16'h02C0, 4'h2, 6'h01, 4'b0100));
      check({30'h0, cclk, esync}, 32'h3);
      check({19'h0, fts}, 32'h0000_1000);
      check({19'h0, ts1}, 32'h0000_0400);
      train(1'b0, 4'h1, 6'h04);
      read_d0();
      check(rd, word(16'h0EC0, 4'h2, 6'h01, 4'b0110));
      repeat (8) @(negedge i_clk);
      read_d0();
      check(rd, word(16'h0EC0, 4'h1, 6'h04, 4'b1100));
      train(1'b1, 4'h2, 6'h01);
      repeat (8) @(negedge i_clk);
      read_d0();
      check(rd, word(16'h0EC0, 4'h1, 6'h04, 4'b0101));
      fail = 1'b0;
      access(1'b1, 8'hD0, 4'h1, 32'h0000_00E0);
      check({30'h0, rt, rt_up}, 32'h2);
      repeat (8) @(negedge i_clk);
      read_d0();
      check(rd, word(16'h0EC0, 4'h2, 6'h01, 4'b1100));
      access(1'b1, 8'hD0, 4'h1, 32'h0000_00D0);
      check({31'h0, ldis}, 32'h1);
      repeat (4) @(negedge i_clk);
      read_d0();
      check(rd, word(16'h0ED0, 4'h2, 6'h01, 4'b0100));
      check(rd_up, word(16'h02C0, 4'h2, 6'h01, 4'b0100));
      @(negedge i_clk);
      sload = 1'b1;
      @(negedge i_clk);
      sload = 1'b0;
      read_d0();
      check(rd, word(16'h0ED0, 4'h2, 6'h01, 4'b0000));
      access(1'b0, 8'hD4, 4'hF, 32'h0);
      check(rd, 32'h0);
      access(1'b1, 8'hD0, 4'h1, 32'h0000_0000);
      check({19'h0, fts}, {19'h0, FTSN});
      check({19'h0, ts1}, {19'h0, TS1N});
      read_d0();
      check(rd, word(16'h0E00, 4'h2, 6'h01, 4'b0000));
      end_of_test();
   end
endmodule : pcie_link_control_status_test
`default_nettype wire

// ---- verification/plcs_partner_model.sv ----
// Link partner model: answers training requests with a result after a delay.
// Assumes the same core clock as the port; bench pulses i_go for one cycle.
`timescale 1ns/1ps
`default_nettype none

module plcs_partner_model #(
   parameter int TRAIN_CYCLES = 4  // Edges from start to result
) (
   input wire logic i_clk,          // Core clock
   input wire logic i_nrst,         // Async reset, active low
   input wire logic i_go,           // Bench asks for training
   input wire logic i_retrain,      // Port asks for retraining
   input wire logic i_link_disable, // Port holds link down
   input wire logic i_fail,         // Result is a failure
   input wire logic [3:0] i_speed,  // Speed to agree
   input wire logic [5:0] i_width,  // Width to agree
   output logic o_train_start,      // Training began pulse
   output logic o_train_fail,       // Training failed pulse
   output logic o_train_l0,         // Reached L0 pulse
   output logic [3:0] o_neg_speed,  // Agreed speed
   output logic [5:0] o_neg_width,  // Agreed width
   output logic o_dl_active         // Data link up
);
   int cnt;
   logic busy;

   // Training sequence; agreed values are garbage outside the L0 pulse
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= 0;
         busy <= 1'b0;
         o_train_start <= 1'b0;
         o_train_fail <= 1'b0;
         o_train_l0 <= 1'b0;
         o_neg_speed <= 4'h0;
         o_neg_width <= 6'h00;
         o_dl_active <= 1'b0;
      end else begin
         o_train_start <= 1'b0;
         o_train_fail <= 1'b0;
         o_train_l0 <= 1'b0;
         o_neg_speed <= ~o_neg_speed;
         o_neg_width <= ~o_neg_width;
         if (i_link_disable) begin
            busy <= 1'b0;
            o_dl_active <= 1'b0;
         end else if (!busy && (i_go || i_retrain)) begin
            busy <= 1'b1;
            cnt <= TRAIN_CYCLES;
            o_dl_active <= 1'b0;
            o_train_start <= 1'b1;
         end else if (busy) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               busy <= 1'b0;
               o_train_fail <= i_fail;
               o_train_l0 <= !i_fail;
               o_dl_active <= !i_fail;
               if (!i_fail) begin
                  o_neg_speed <= i_speed;
                  o_neg_width <= i_width;
               end
            end
         end
      end
   end
endmodule : plcs_partner_model
`default_nettype wire
